// ===== inc/epwm_pkg.sv
// constants of the enhanced pwm stage: register map, fields, resets
// assumes one 200 MHz core clock and an apb register port
package epwm_pkg;
   // -----------------------------------------------------------
   // register byte offsets
   // -----------------------------------------------------------
   localparam logic [7:0] OFF_PERIOD = 8'h00;
   localparam logic [7:0] OFF_DUTY   = 8'h04;
   localparam logic [7:0] OFF_CTRL   = 8'h08;
   localparam logic [7:0] OFF_TCTRL  = 8'h0C;
   localparam logic [7:0] OFF_DBAND  = 8'h10;
   localparam logic [7:0] OFF_SDCTRL = 8'h14;
   localparam logic [7:0] OFF_STATUS = 8'h18;
   // -----------------------------------------------------------
   // field positions
   // -----------------------------------------------------------
   localparam int CTRL_MODE_LSB  = 2;
   localparam int CTRL_DLO_LSB   = 4;
   localparam int CTRL_CFG_LSB   = 6;
   localparam int TCTRL_PS_LSB   = 0;
   localparam int TCTRL_ON_BIT   = 2;
   localparam int DB_CNT_LSB     = 0;
   localparam int DB_RESTART_BIT = 7;
   localparam int SD_BD_LSB      = 0;
   localparam int SD_AC_LSB      = 2;
   localparam int SD_SRC_LSB     = 4;
   localparam int SD_FLAG_BIT    = 7;
   // -----------------------------------------------------------
   // encodings and reset values
   // -----------------------------------------------------------
   localparam logic [1:0] MODE_PWM   = 2'h3;
   localparam logic [1:0] CFG_HALF   = 2'h2;
   localparam logic [1:0] PS_DIV1    = 2'h0;
   localparam logic [1:0] PS_DIV4    = 2'h1;
   localparam logic [1:0] LVL_LOW    = 2'h0;
   localparam logic [1:0] LVL_HIGH   = 2'h1;
   localparam logic [5:0] SUB_MAX1   = 6'h03;
   localparam logic [5:0] SUB_MAX4   = 6'h0F;
   localparam logic [5:0] SUB_MAX16  = 6'h3F;
   localparam logic [7:0] RST_PERIOD = 8'hFF;
   localparam logic [7:0] RST_BYTE   = 8'h00;
   localparam int TCY_CLKS = 4;
endpackage : epwm_pkg

// ===== hdl/epwm_sync.sv
// two-flop synchroniser for pins entering the core clock domain
// assumes inputs are quasi-static levels from pins or comparators
module epwm_sync #(
   parameter int unsigned W = 1
) (
   input  wire logic         core_clk_i,
   input  wire logic         rst_n_i,
   input  wire logic [W-1:0] async_i,
   output logic      [W-1:0] sync_o
);
   logic [W-1:0] meta_q;
   logic [W-1:0] sync_q;

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= async_i;
         sync_q <= meta_q;
      end
   end

   assign sync_o = sync_q;
endmodule : epwm_sync

// ===== hdl/epwm_dead_band.sv
// delays the rising edge of one drive signal by a count of
// instruction cycles; falling edges pass after one clock
// assumes tick_i pulses once every instruction cycle
module epwm_dead_band #(
   parameter int unsigned W = 7
) (
   input  wire logic         core_clk_i,
   input  wire logic         rst_n_i,
   input  wire logic         level_i,
   input  wire logic         tick_i,
   input  wire logic [W-1:0] count_i,
   output logic              level_o
);
   logic [W-1:0] elapsed_q;
   logic         out_q;

   // elapsed time since the rising edge, saturating
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         elapsed_q <= '0;
      end else if (!level_i) begin
         elapsed_q <= '0;
      end else if (tick_i && elapsed_q != {W{1'b1}}) begin
         elapsed_q <= elapsed_q + 1'b1; // [RQ7]
      end
   end

   // rises on a tick, so the gap is whole cycles; a raised count
   // still bites at once, even mid-pulse
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         out_q <= 1'b0;
      end else begin
         out_q <= level_i && (elapsed_q >= count_i)
                  && (tick_i || out_q); // [RQ6] [RQ7] [RQ15]
      end
   end

   assign level_o = out_q;
endmodule : epwm_dead_band

// ===== hdl/epwm_top.sv
// enhanced pwm output stage: period timer, double-buffered duty,
// half-bridge dead band and auto-shutdown, behind an apb slave
// assumes a 200 MHz core clock (the oscillator) and apb master
//
// Chosen here: the APB slave port and the register offsets.

// Notes on behaviour
// [RQ1] shadowed duty, cleared on 10-bit timer match
// [RQ2] duty beyond period never clears output
// [RQ3] prescale 1, 4, 16; 10-bit duty resolution
// [RQ4] plain variant has no auto-shutdown
// [RQ5] software loads period, duty, pin, timer, mode
// [RQ6] dead band only on inactive-to-active edges
// [RQ7] 7-bit dead band in instruction cycles
// [RQ8] shutdown event forces enabled pins at once
// [RQ9] sources: two comparators, low fault pin
// [RQ10] per-pair shutdown level: high, low, float
// [RQ11] hardware sets sticky shutdown flag, holds outputs
// [RQ12] flag cleared by restart or firmware
// [RQ13] shutdown lasts whole period; resume next period
// [RQ14] flag writes ignored while cause persists
// [RQ15] raised dead band takes effect immediately
// [RQ16] period match resets timer, sets output, loads
module epwm_top #(
   parameter int unsigned ENHANCED = 1,
   parameter int unsigned DB_W     = 7
) (
   // clock and reset
   input  wire logic        core_clk_i,
   input  wire logic        rst_n_i,
   // apb slave
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [7:0]  paddr_i,
   input  wire logic [31:0] pwdata_i,
   output logic      [31:0] prdata_o,
   output logic             pready_o,
   output logic             pslverr_o,
   // shutdown sources
   input  wire logic [1:0]  cmp_out_i,
   input  wire logic        fault_input_n_i,
   // bridge drive pins
   output logic             pwm_output_a_o,
   output logic             pwm_output_a_oe_o,
   output logic             pwm_output_b_o,
   output logic             pwm_output_b_oe_o,
   output logic             pwm_output_c_o,
   output logic             pwm_output_c_oe_o,
   output logic             pwm_output_d_o,
   output logic             pwm_output_d_oe_o
);
   // -----------------------------------------------------------
   // elaboration checks
   // -----------------------------------------------------------
   if (ENHANCED > 1) begin : g_bad_variant
      $error("ENHANCED must be 0 or 1");
   end
   if (DB_W != 7) begin : g_bad_dbw
      $error("dead band count must be 7 bits wide");
   end

   // -----------------------------------------------------------
   // declarations
   // -----------------------------------------------------------
   typedef enum logic [1:0] {
      EPWM_RUN,
      EPWM_TRIP,
      EPWM_HOLD
   } epwm_sd_state_t;

   logic [7:0]      period_q;
   logic [7:0]      duty_hi_q;
   logic [7:0]      ctrl_q;
   logic [2:0]      tctrl_q;
   logic [7:0]      dband_q;
   logic [6:0]      sdcfg_q;
   logic            flag_q;
   logic [31:0]     rdata_q;
   logic [9:0]      shadow_q;
   logic [7:0]      timer_q;
   logic [5:0]      sub_q;
   logic [1:0]      q_q;
   logic            raw_q;
   epwm_sd_state_t  sd_q;
   epwm_sd_state_t  sd_d;
   logic [1:0]      cmp_s;
   logic            fault_n_s;
   logic            wr_en;
   logic            rd_setup;
   logic            tmr_on;
   logic [1:0]      ps;
   logic [5:0]      sub_max;
   logic            tick;
   logic            period_start;
   logic [1:0]      fine;
   logic            pwm_en;
   logic            half;
   logic            cause;
   logic            sd_now;
   logic            db_tick;
   logic            db_a;
   logic            db_b;
   logic [1:0]      lvl_ac;
   logic [1:0]      lvl_bd;
   logic            a_n;
   logic            b_n;
   logic            a_en;
   logic            b_en;

   // -----------------------------------------------------------
   // address decode
   // -----------------------------------------------------------
   function automatic logic epwm_mapped(input logic [7:0] a);
      case (a)
         epwm_pkg::OFF_PERIOD,
         epwm_pkg::OFF_DUTY,
         epwm_pkg::OFF_CTRL,
         epwm_pkg::OFF_TCTRL,
         epwm_pkg::OFF_DBAND,
         epwm_pkg::OFF_SDCTRL,
         epwm_pkg::OFF_STATUS: epwm_mapped = 1'b1;
         default:              epwm_mapped = 1'b0;
      endcase
   endfunction : epwm_mapped

   // zero wait states; unmapped words answer with an error
   assign pready_o  = 1'b1;
   assign pslverr_o = psel_i && penable_i && !epwm_mapped(paddr_i);
   assign wr_en     = psel_i && penable_i && pwrite_i
                      && epwm_mapped(paddr_i);
   assign rd_setup  = psel_i && !penable_i && !pwrite_i;
   assign prdata_o  = rdata_q;

   // -----------------------------------------------------------
   // pin synchronisers
   // -----------------------------------------------------------
   epwm_sync #(
      .W (3)
   ) u_sync (
      .core_clk_i (core_clk_i),
      .rst_n_i    (rst_n_i),
      .async_i    ({fault_input_n_i, cmp_out_i}),
      .sync_o     ({fault_n_s, cmp_s})
   );

   // -----------------------------------------------------------
   // configuration registers
   // -----------------------------------------------------------
   // software order period, duty, pins, timer, mode is not enforced
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         period_q  <= epwm_pkg::RST_PERIOD;
         duty_hi_q <= epwm_pkg::RST_BYTE;
         ctrl_q    <= epwm_pkg::RST_BYTE;
         tctrl_q   <= 3'h0;
         dband_q   <= epwm_pkg::RST_BYTE;
         sdcfg_q   <= 7'h00;
      end else if (wr_en) begin
         case (paddr_i)
            epwm_pkg::OFF_PERIOD: period_q  <= pwdata_i[7:0];
            epwm_pkg::OFF_DUTY:   duty_hi_q <= pwdata_i[7:0];
            epwm_pkg::OFF_CTRL:   ctrl_q    <= pwdata_i[7:0]; // [RQ5]
            epwm_pkg::OFF_TCTRL:  tctrl_q   <= pwdata_i[2:0];
            epwm_pkg::OFF_DBAND:  dband_q   <= pwdata_i[7:0];
            epwm_pkg::OFF_SDCTRL: sdcfg_q   <= pwdata_i[6:0];
            default: ;
         endcase
      end
   end

   // -----------------------------------------------------------
   // read data, captured in the setup phase
   // -----------------------------------------------------------
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rdata_q <= 32'h0000_0000;
      end else if (rd_setup) begin
         case (paddr_i)
            epwm_pkg::OFF_PERIOD: rdata_q <= {24'h0, period_q};
            epwm_pkg::OFF_DUTY:   rdata_q <= {24'h0, duty_hi_q};
            epwm_pkg::OFF_CTRL:   rdata_q <= {24'h0, ctrl_q};
            epwm_pkg::OFF_TCTRL:  rdata_q <= {29'h0, tctrl_q};
            epwm_pkg::OFF_DBAND:  rdata_q <= {24'h0, dband_q};
            epwm_pkg::OFF_SDCTRL: rdata_q <= {24'h0, flag_q, sdcfg_q};
            epwm_pkg::OFF_STATUS: rdata_q <= {21'h0, sd_now, cause,
                                              raw_q, timer_q};
            default:              rdata_q <= 32'h0000_0000;
         endcase
      end
   end

   // -----------------------------------------------------------
   // prescaler and instruction cycle
   // -----------------------------------------------------------
   assign tmr_on = tctrl_q[epwm_pkg::TCTRL_ON_BIT];
   assign ps     = tctrl_q[epwm_pkg::TCTRL_PS_LSB +: 2];

   // only three ratios; both upper codes mean divide by 16
   always_comb begin
      case (ps)
         epwm_pkg::PS_DIV1: begin
            sub_max = epwm_pkg::SUB_MAX1; // [RQ3]
            fine    = sub_q[1:0];
         end
         epwm_pkg::PS_DIV4: begin
            sub_max = epwm_pkg::SUB_MAX4;
            fine    = sub_q[3:2];
         end
         default: begin
            sub_max = epwm_pkg::SUB_MAX16;
            fine    = sub_q[5:4];
         end
      endcase
   end

   assign tick         = tmr_on && (sub_q == sub_max);
   assign period_start = tick && (timer_q == period_q);

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sub_q <= 6'h00;
      end else if (!tmr_on || tick) begin
         sub_q <= 6'h00;
      end else begin
         sub_q <= sub_q + 6'h01;
      end
   end

   // free-running quarter counter for the dead band
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         q_q <= 2'h0;
      end else begin
         q_q <= q_q + 2'h1;
      end
   end
   assign db_tick = (q_q == 2'(epwm_pkg::TCY_CLKS - 1)); // [RQ7]

   // -----------------------------------------------------------
   // period timer and duty shadow
   // -----------------------------------------------------------
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         timer_q <= 8'h00;
      end else if (period_start) begin
         timer_q <= 8'h00; // [RQ16]
      end else if (tick) begin
         timer_q <= timer_q + 8'h01;
      end
   end

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         shadow_q <= 10'h000;
      end else if (period_start) begin
         shadow_q <= {duty_hi_q,
                      ctrl_q[epwm_pkg::CTRL_DLO_LSB +: 2]}; // [RQ1] [RQ16]
      end
   end

   // a duty above the period never matches before the timer wraps
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         raw_q <= 1'b0;
      end else if (!pwm_en) begin
         raw_q <= 1'b0;
      end else if (period_start) begin
         raw_q <= 1'b1; // [RQ16]
      end else if ({timer_q, fine} == shadow_q) begin
         raw_q <= 1'b0; // [RQ1] [RQ2] [RQ3]
      end
   end

   // -----------------------------------------------------------
   // half-bridge dead band
   // -----------------------------------------------------------
   assign pwm_en = ctrl_q[epwm_pkg::CTRL_MODE_LSB +: 2]
                   == epwm_pkg::MODE_PWM;
   assign half   = ctrl_q[epwm_pkg::CTRL_CFG_LSB +: 2]
                   == epwm_pkg::CFG_HALF;

   epwm_dead_band #(
      .W (DB_W)
   ) u_db_a (
      .core_clk_i (core_clk_i),
      .rst_n_i    (rst_n_i),
      .level_i    (raw_q && half),
      .tick_i     (db_tick),
      .count_i    (dband_q[epwm_pkg::DB_CNT_LSB +: DB_W]), // [RQ7]
      .level_o    (db_a)
   );

   epwm_dead_band #(
      .W (DB_W)
   ) u_db_b (
      .core_clk_i (core_clk_i),
      .rst_n_i    (rst_n_i),
      .level_i    (!raw_q && half && pwm_en),
      .tick_i     (db_tick),
      .count_i    (dband_q[epwm_pkg::DB_CNT_LSB +: DB_W]),
      .level_o    (db_b)
   );

   // -----------------------------------------------------------
   // auto-shutdown
   // -----------------------------------------------------------
   // plain variant ties the cause off, so only a firmware flag write can trip
   assign cause = (ENHANCED == 1) && pwm_en // [RQ4]
                  && |(sdcfg_q[epwm_pkg::SD_SRC_LSB +: 3]
                       & {!fault_n_s, cmp_s}); // [RQ9]

   // set beats any clear in the same cycle
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         flag_q <= 1'b0;
      end else if (cause) begin
         flag_q <= 1'b1; // [RQ11] [RQ14]
      end else if (dband_q[epwm_pkg::DB_RESTART_BIT]) begin
         flag_q <= 1'b0; // [RQ12]
      end else if (wr_en && paddr_i == epwm_pkg::OFF_SDCTRL) begin
         flag_q <= pwdata_i[epwm_pkg::SD_FLAG_BIT]; // [RQ12]
      end
   end

   // leaves shutdown only at a period boundary, or once pwm mode is off, with the flag clear
   always_comb begin
      sd_d = sd_q;
      case (sd_q)
         EPWM_RUN: begin
            if (cause || flag_q) begin
               sd_d = EPWM_TRIP;
            end
         end
         EPWM_TRIP: begin
            if (!cause && !flag_q) begin
               sd_d = EPWM_HOLD;
            end
         end
         EPWM_HOLD: begin
            if (cause || flag_q) begin
               sd_d = EPWM_TRIP;
            end else if (period_start || !pwm_en) begin
               sd_d = EPWM_RUN; // [RQ13]
            end
         end
         default: sd_d = EPWM_RUN;
      endcase
   end

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sd_q <= EPWM_RUN;
      end else begin
         sd_q <= sd_d;
      end
   end

   // cause bypasses the state so pins trip without a clock edge
   assign sd_now = cause || flag_q || (sd_q != EPWM_RUN); // [RQ8] [RQ11]

   // -----------------------------------------------------------
   // pin drive
   // -----------------------------------------------------------
   assign a_n    = half ? db_a : raw_q;
   assign b_n    = db_b;
   assign a_en   = pwm_en;
   assign b_en   = pwm_en && half;
   assign lvl_ac = sdcfg_q[epwm_pkg::SD_AC_LSB +: 2];
   assign lvl_bd = sdcfg_q[epwm_pkg::SD_BD_LSB +: 2];

   // pair levels: low, high, or released when the top bit is set
   always_comb begin
      pwm_output_c_o    = 1'b0;
      pwm_output_c_oe_o = 1'b0;
      pwm_output_d_o    = 1'b0;
      pwm_output_d_oe_o = 1'b0;
      if (sd_now) begin
         pwm_output_a_o    = (lvl_ac == epwm_pkg::LVL_HIGH); // [RQ10]
         pwm_output_a_oe_o = a_en && !lvl_ac[1]; // [RQ8]
         pwm_output_b_o    = (lvl_bd == epwm_pkg::LVL_HIGH); // [RQ10]
         pwm_output_b_oe_o = b_en && !lvl_bd[1];
      end else begin
         pwm_output_a_o    = a_n;
         pwm_output_a_oe_o = a_en;
         pwm_output_b_o    = b_n;
         pwm_output_b_oe_o = b_en;
      end
   end
endmodule : epwm_top

// ===== sim/epwm_props.sv
// checker: pin forcing, dead band and bus answer of the pwm stage
// assumes binding to epwm_top; configuration is snooped from apb
module epwm_props (
   // clock and reset
   input wire logic        core_clk_i,
   input wire logic        rst_n_i,
   // apb
   input wire logic        psel_i,
   input wire logic        penable_i,
   input wire logic        pwrite_i,
   input wire logic [7:0]  paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic        pready_o,
   // pins
   input wire logic        fault_input_n_i,
   input wire logic        pwm_output_a_o,
   input wire logic        pwm_output_a_oe_o,
   input wire logic        pwm_output_b_o,
   input wire logic        pwm_output_b_oe_o,
   input wire logic        pwm_output_c_oe_o,
   input wire logic        pwm_output_d_oe_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // ------
   // snooped configuration
   // ------
   logic [7:0] sd_q;
   logic [7:0] ctl_q;
   wire logic wr = psel_i && penable_i && pwrite_i;
   wire logic pwm = ctl_q[epwm_pkg::CTRL_MODE_LSB +: 2] == epwm_pkg::MODE_PWM;
   wire logic half = pwm && ctl_q[7:6] == epwm_pkg::CFG_HALF;
   wire logic calm = pwm && sd_q[6:4] == 3'h0;
   wire logic flt = pwm && sd_q[6] && !fault_input_n_i;
   wire logic ac_ok = sd_q[3] ? !pwm_output_a_oe_o
                      : pwm_output_a_oe_o && pwm_output_a_o == sd_q[2];
   wire logic bd_ok = sd_q[1] ? !pwm_output_b_oe_o
                      : pwm_output_b_oe_o && pwm_output_b_o == sd_q[0];
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) sd_q <= 8'h00;
      else if (wr && paddr_i == epwm_pkg::OFF_SDCTRL) sd_q <= pwdata_i[7:0];
   end
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) ctl_q <= 8'h00;
      else if (wr && paddr_i == epwm_pkg::OFF_CTRL) ctl_q <= pwdata_i[7:0];
   end
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!rst_n_i);
   // ------
   // properties
   // ------
   property p_cd_float;
      !pwm_output_c_oe_o && !pwm_output_d_oe_o;
   endproperty
   a_cd_float: assert property (p_cd_float)
      else $error("pin c or d driven");
   property p_fault_ac;
      flt [*4] |-> ac_ok;
   endproperty
   a_fault_ac: assert property (p_fault_ac)
      else $error("pair ac not forced");
   property p_fault_bd;
      (flt && half) [*4] |-> bd_ok;
   endproperty
   a_fault_bd: assert property (p_fault_bd)
      else $error("pair bd not forced");
   property p_hold_ac;
      flt [*4] ##1 fault_input_n_i |-> ac_ok [*2];
   endproperty
   a_hold_ac: assert property (p_hold_ac)
      else $error("shutdown released early");
   property p_half_excl;
      half && calm |-> !(pwm_output_a_o && pwm_output_b_o);
   endproperty
   a_half_excl: assert property (p_half_excl)
      else $error("both bridge drives high");
   property p_oe_run;
      calm |-> pwm_output_a_oe_o;
   endproperty
   a_oe_run: assert property (p_oe_run)
      else $error("pin a not driven in pwm mode");
   property p_dead_gap;
      half && calm && $rose(pwm_output_a_o) |-> !$past(pwm_output_b_o, 4);
   endproperty
   a_dead_gap: assert property (p_dead_gap)
      else $error("dead band shorter than one instruction cycle");
   property p_ready;
      psel_i && penable_i |-> pready_o;
   endproperty
   a_ready: assert property (p_ready)
      else $error("access not answered");
endmodule : epwm_props

bind epwm_top epwm_props u_props (.core_clk_i, .rst_n_i, .psel_i, .penable_i,
   .pwrite_i, .paddr_i, .pwdata_i, .pready_o, .fault_input_n_i,
   .pwm_output_a_o, .pwm_output_a_oe_o, .pwm_output_b_o, .pwm_output_b_oe_o,
   .pwm_output_c_oe_o, .pwm_output_d_oe_o);

// ===== sim/epwm_bridge_model.sv
// power switch pair of one half bridge, with an overcurrent sense
// assumes pin a gates the high side, pin b the low side, high = on
module epwm_bridge_model (
   // clock
   input  wire logic core_clk_i,
   // gate drive
   input  wire logic hi_i,
   input  wire logic hi_oe_i,
   input  wire logic lo_i,
   input  wire logic lo_oe_i,
   // sense and event count
   output logic      sense_o,
   output int        shoot_cnt_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // an undriven gate is pulled off by its gate resistor
   wire logic hi_on = hi_oe_i && hi_i;
   wire logic lo_on = lo_oe_i && lo_i;
   // both on shorts the supply: the sense trips at once
   assign sense_o = hi_on && lo_on;
   initial shoot_cnt_o = 0;
   always @(posedge core_clk_i) begin
      if (sense_o) shoot_cnt_o <= shoot_cnt_o + 1;
   end
endmodule : epwm_bridge_model

// ===== sim/tb.sv
// bench of the pwm stage: registers, period, duty, dead band, shutdown
// assumes the apb slave answers with pready and a bridge on pins a, b
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        core_clk_i = 1'b0;
   logic        rst_n_i = 1'b0;
   logic        psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
   logic [7:0]  paddr_i = 8'h00;
   logic [31:0] pwdata_i = 32'h0, prdata_o;
   logic        pready_o, pslverr_o, flt_n = 1'b1, cmp0 = 1'b0, cmp1 = 1'b0;
   logic        a, a_oe, b, b_oe, sense;
   int          err_count = 0, compares = 0, shoots;
   wire logic [1:0] cmp = {cmp1, cmp0 | sense};
   always #2.5 core_clk_i = ~core_clk_i;
   epwm_top dut (.core_clk_i, .rst_n_i, .psel_i, .penable_i, .pwrite_i,
      .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .cmp_out_i(cmp),
      .fault_input_n_i(flt_n), .pwm_output_a_o(a), .pwm_output_a_oe_o(a_oe),
      .pwm_output_b_o(b), .pwm_output_b_oe_o(b_oe), .pwm_output_c_o(),
      .pwm_output_c_oe_o(), .pwm_output_d_o(), .pwm_output_d_oe_o());
   epwm_bridge_model u_bridge (.core_clk_i, .hi_i(a), .hi_oe_i(a_oe),
      .lo_i(b), .lo_oe_i(b_oe), .sense_o(sense), .shoot_cnt_o(shoots));
   // ------
   // tasks
   // ------
   task automatic conclude;
      $display("mismatches %0d comparisons %0d", err_count, compares);
      if (err_count == 0 && compares > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : conclude
   task automatic chk(input string nm, input logic [31:0] e, g);
      compares++;
      if (g !== e) begin
         err_count++;
         $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [7:0] ad,
                      input logic [31:0] wd, output logic [31:0] rd,
                      output logic er);
      int n;
      @(posedge core_clk_i);
      psel_i <= 1'b1;
      pwrite_i <= w;
      paddr_i <= ad;
      pwdata_i <= wd;
      @(posedge core_clk_i);
      penable_i <= 1'b1;
      for (n = 0; n < 16; n++) begin
         @(posedge core_clk_i);
         if (pready_o === 1'b1) break;
      end
      if (n == 16) begin
         err_count++;
         conclude();
      end
      rd = prdata_o;
      er = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
   endtask : apb
   task automatic wr(input logic [7:0] ad, input logic [31:0] wd);
      logic [31:0] r;
      logic e;
      apb(1'b1, ad, wd, r, e);
   endtask : wr
   task automatic rdc(input string nm, input logic [7:0] ad,
                      input logic [31:0] ex, input logic ee);
      logic [31:0] r;
      logic e;
      apb(1'b0, ad, 32'h0, r, e);
      chk(nm, ex, r);
      chk(nm, {31'h0, ee}, {31'h0, e});
   endtask : rdc
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk_i);
      #1;
   endtask : tick
   // sel 0 times rise to rise of a; sel 1 and 2 time the dead band gaps
   task automatic span(input int sel, output int per, output int hi);
      int n, st;
      logic x, y, px;
      per = 0;
      hi = 0;
      st = 0;
      px = sel == 0 ? 1'b1 : 1'b0;
      for (n = 0; n < 20000 && st < 2; n++) begin
         tick(1);
         x = sel == 2 ? a : b;
         y = sel == 2 ? b : a;
         if (st == 1) per++;
         if (st == 1) hi += a;
         if (sel == 0 && a && !px) st++;
         else if (sel > 0 && st == 0 && px && !x) st = 1;
         else if (sel > 0 && st == 1 && y) st = 2;
         px = sel == 0 ? a : x;
      end
      if (st < 2) begin
         err_count++;
         conclude();
      end
   endtask : span
   task automatic cause(input int i, input logic v);
      cmp0 <= i == 0 && v;
      cmp1 <= i == 1 && v;
      flt_n <= !(i == 2 && v);
   endtask : cause
   // ------
   // main sequence
   // ------
   initial begin
      int i, p, d1, d2, h1, h2, per, g, nb, dv;
      logic [31:0] sd;
      p = $urandom(68);
      repeat (12) @(posedge core_clk_i);
      rst_n_i <= 1'b1;
      rdc("period", epwm_pkg::OFF_PERIOD, 32'hFF, 1'b0);
      for (i = 1; i < 7; i++) rdc("reg", 8'(4 * i), 32'h0, 1'b0);
      rdc("unmapped", 8'h1C, 32'h0, 1'b1);
      $display("test reset done");
      for (i = 0; i < 3; i++) begin
         dv = 1 << (2 * i);
         p = 2 + $urandom % 8;
         d1 = 1 + $urandom % (4 * p);
         d2 = 1 + $urandom % (4 * p + 2);
         wr(epwm_pkg::OFF_PERIOD, 32'(p));
         wr(epwm_pkg::OFF_DUTY, 32'(d1 >> 2));
         wr(epwm_pkg::OFF_CTRL, 32'(8'h0F | (d1 & 3) << 4));
         wr(epwm_pkg::OFF_TCTRL, 32'(4 | i));
         span(0, per, h1);
         chk("period", 32'((p + 1) * 4 * dv), 32'(per));
         wr(epwm_pkg::OFF_DUTY, 32'(d2 >> 2));
         wr(epwm_pkg::OFF_CTRL, 32'(8'h0F | (d2 & 3) << 4));
         span(0, per, h2);
         chk("duty step", 32'(h1 + (d2 - d1) * dv), 32'(h2));
      end
      wr(epwm_pkg::OFF_DUTY, 32'(p + 1 + $urandom % 8));
      tick((p + 1) * 128);
      nb = 0;
      for (i = 0; i < (p + 1) * 192; i++) begin
         tick(1);
         nb += !a;
      end
      chk("no clear", 32'h0, 32'(nb));
      $display("test period and duty done");
      nb = 1 + $urandom % 7;
      p = 40 + $urandom % 20;
      wr(epwm_pkg::OFF_TCTRL, 32'h4);
      wr(epwm_pkg::OFF_PERIOD, 32'(p));
      wr(epwm_pkg::OFF_DUTY, 32'(p / 2));
      wr(epwm_pkg::OFF_DBAND, 32'(nb));
      wr(epwm_pkg::OFF_CTRL, 32'h8F);
      for (i = 1; i < 3; i++) begin
         span(i, g, h1);
         span(i, g, h1);
         chk("gap", 32'h1, 32'(g >= 4 * nb && g <= 4 * nb + 5));
      end
      chk("shoot", 32'h0, 32'(shoots));
      $display("test dead band done");
      for (i = 0; i < 3; i++) begin
         sd = (32'h10 << i) | (i == 0 ? 32'h4 : i == 1 ? 32'h2 : 32'h9);
         wr(epwm_pkg::OFF_SDCTRL, sd);
         cause(i, 1'b1);
         tick(6);
         chk("pair ac", {!sd[3], sd[2] & !sd[3]}, {a_oe, a & a_oe});
         chk("pair bd", {!sd[1], sd[0] & !sd[1]}, {b_oe, b & b_oe});
         rdc("flag set", epwm_pkg::OFF_SDCTRL, sd | 32'h80, 1'b0);
         wr(epwm_pkg::OFF_SDCTRL, sd);
         rdc("flag kept", epwm_pkg::OFF_SDCTRL, sd | 32'h80, 1'b0);
         cause(i, 1'b0);
         tick(6);
         chk("hold ac", {!sd[3], sd[2] & !sd[3]}, {a_oe, a & a_oe});
         wr(epwm_pkg::OFF_SDCTRL, sd);
         rdc("flag clear", epwm_pkg::OFF_SDCTRL, sd, 1'b0);
         span(0, per, h1);
         chk("resume", 32'h1, {31'h0, a_oe});
      end
      wr(epwm_pkg::OFF_DBAND, 32'(8'h80 | nb));
      cause(2, 1'b1);
      tick(6);
      rdc("auto set", epwm_pkg::OFF_SDCTRL, sd | 32'h80, 1'b0);
      cause(2, 1'b0);
      tick(8);
      rdc("auto clear", epwm_pkg::OFF_SDCTRL, sd, 1'b0);
      $display("test shutdown done");
      conclude();
   end
endmodule : tb
